// ### design/cfg_fifo.sv
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two.
*/
module cfg_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_sys,    // System clock
    input  wire logic             rstn,       // Async reset, active low
    input  wire logic             in_valid,   // Write request
    output logic                  in_ready,   // Not full
    input  wire logic [WIDTH-1:0] in_data,    // Write data
    output logic                  out_valid,  // Not empty
    input  wire logic             out_ready,  // Reader takes word
    output logic      [WIDTH-1:0] out_data    // Head word
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    // Handshake decode
    assign in_ready  = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_ff[rp_ff];

    // Storage
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_ff[wp_ff] <= in_data;
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wp_ff  <= push ? wp_ff + 1'b1 : wp_ff;
            rp_ff  <= pop ? rp_ff + 1'b1 : rp_ff;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : cfg_fifo

// ### design/cfg_pins_pkg.sv
/*
 Shared constants, state and mode types, and request carriers for the
 configuration and host port logic.
 Assumes a single 20 MHz system clock.
*/
package cfg_pins_pkg;

    // Clock rate and derived timing
    localparam int CLK_MHZ   = 20;
    localparam int POR_NS    = 2000;                          // Power settle time
    localparam int CLEAR_NS  = 5000;                          // Memory clear time
    localparam int POR_CYC   = (POR_NS * CLK_MHZ + 999) / 1000;
    localparam int CLEAR_CYC = (CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W     = 8;

    // Widths
    localparam int DATA_W  = 32;
    localparam int BYTE_W  = 8;
    localparam int MADDR_W = 22;
    localparam int HADDR_W = 18;
    localparam int FIFO_DEPTH = 8;

    // Host transfer size codes
    localparam logic [1:0] TSZ_WORD = 2'h0;
    localparam logic [1:0] TSZ_BYTE = 2'h1;
    localparam logic [1:0] TSZ_HALF = 2'h2;

    // Host register store and burst shape
    localparam int HOST_WORDS = 4;
    localparam int WIDX_LSB   = 2;
    localparam logic [1:0] BEAT_LAST = 2'h3;

    // Internal sink pacing, status lane layout
    localparam logic [2:0]  CONSUME_CYC = 3'h4;
    localparam logic [31:0] STAT_OE     = 32'h0000_00f8;
    localparam int          STAT_LSB    = 3;

    typedef enum logic [1:0] {MODE_ASYNC, MODE_MASTER, MODE_HOST} cfg_mode_t;
    typedef enum logic [2:0] {ST_POWER, ST_CLEAR, ST_WAIT, ST_LOAD, ST_DONE} cfg_state_t;
    typedef enum logic [0:0] {HS_IDLE, HS_BEAT} host_state_t;

    // One captured host request
    typedef struct packed {
        logic               rd;
        logic [HADDR_W-1:0] addr;
        logic [1:0]         size;
        logic               burst_n;
    } host_req_t;

endpackage : cfg_pins_pkg

// ### design/config_and_host_port_pins.sv
/*
 Configuration loader and host bus port behind the configuration pins.
 Assumes all pins except the async strobes are synchronous to clk_sys,
 and that the mode straps are stable when the init line rises.
*/
module config_and_host_port_pins
    import cfg_pins_pkg::*;
#(
    parameter logic [21:0] CFG_BYTES = 22'h00_0100
)
(
    input  wire logic                      clk_sys,              // System clock
    input  wire logic                      rstn,                 // Async reset
    input  wire cfg_pins_pkg::cfg_mode_t   cfg_mode,             // Mode straps
    input  wire logic                      bscan_sel,            // Test port chosen
    input  wire logic                      strb_stat_en,         // Strobe as status
    input  wire logic                      select_low_n,         // Select, low
    input  wire logic                      select_high,          // Select, high
    input  wire logic                      host_transfer_strobe, // Read strobe
    input  wire logic                      host_read_not_write,  // Write strobe
    input  wire logic [17:0]               host_addr,            // Host address
    input  wire logic                      host_burst_n,         // Burst, low
    input  wire logic                      host_burst_continue,  // Next beat
    input  wire logic [1:0]                host_xfer_size,       // Size code
    output logic                           host_xfer_ack_n,      // Beat ack
    input  wire logic [31:0]               d_i,                  // Data in
    output logic      [31:0]               d_o,                  // Data out
    output logic      [31:0]               d_oe,                 // Data enable
    output logic                           ready_o,              // Byte room
    output logic                           rclk_o,               // Memory clock
    output logic      [21:0]               mem_addr_o,           // Memory addr
    output logic                           cfg_busy_high,        // High in config
    output logic                           cfg_busy_low,         // Low in config
    input  wire logic                      init_i,               // Init level
    output logic                           init_o,               // Init out
    output logic                           init_oe,              // Init drive
    output logic                           bscan_off,            // Scan inhibit
    output logic                           rw_user_io,           // Pin freed
    output logic                           strb_o,               // Status level
    output logic                           strb_oe               // Status drive
);
    import cfg_pins_pkg::*;

    localparam logic [21:0] CFG_LAST = CFG_BYTES - 22'h1;

    // Byte lanes of a size code
    function automatic logic [31:0] lane_mask(input logic [1:0] sz);
        case (sz)
            TSZ_BYTE: lane_mask = 32'h0000_00ff;
            TSZ_HALF: lane_mask = 32'h0000_ffff;
            default:  lane_mask = 32'hffff_ffff;
        endcase
    endfunction : lane_mask

    cfg_state_t   st_ff, nxt_st;
    host_state_t  hs_ff;
    cfg_mode_t    mode_ff;
    host_req_t    req_ff;
    logic [TMR_W-1:0]   tmr_ff;
    logic [1:0]         beat_ff;
    logic [2:0]         sink_ff;
    logic [MADDR_W-1:0] bytes_ff, mem_addr_ff;
    logic [DATA_W-1:0]  hmem_ff [HOST_WORDS];
    logic [DATA_W-1:0]  d_o_ff, d_oe_ff, nxt_d_o, nxt_d_oe;
    logic ready_ff, rclk_ff, mp_done_ff, ack_n_ff, busy_h_ff, busy_l_ff;
    logic init_o_ff, init_oe_ff, bscan_off_ff, rw_user_ff, strb_o_ff, strb_oe_ff;

    logic [1:0] lvl_n, fall;
    logic       rd_n_s, wr_n_s, wr_fall;
    logic       selected, async_ld, mp_ld, take, rd_act, wr_act;
    logic       mp_take, rclk_step, f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic       pop, load_end, h_start, h_more, h_beat;
    logic [7:0] f_out_data, fifo_in;
    logic [1:0] widx;
    logic [4:0] sh;
    logic [31:0] bmask, rword, wword;

    // Async strobes synchronised before use
    strobe_sync u_sync
    (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .strobe_n ({host_read_not_write, host_transfer_strobe}),
        .level_n  (lvl_n),
        .fall     (fall)
    );
    assign rd_n_s  = lvl_n[0];
    assign wr_n_s  = lvl_n[1];
    assign wr_fall = fall[1];

    // Selection and load decode
    assign selected = !select_low_n && select_high;
    assign async_ld = st_ff == ST_LOAD && mode_ff != MODE_MASTER;
    assign mp_ld    = st_ff == ST_LOAD && mode_ff == MODE_MASTER;
    assign take     = async_ld && selected && wr_fall;
    assign wr_act   = async_ld && selected && !wr_n_s;
    assign rd_act   = async_ld && selected && !rd_n_s && !wr_act;

    // Master parallel fetch: address out, clock high, sample, advance
    assign mp_take   = mp_ld && rclk_ff && f_in_ready && !mp_done_ff;
    assign rclk_step = mp_ld && !mp_done_ff && (!rclk_ff || f_in_ready);

    // Both sources feed the byte FIFO
    assign f_in_valid = take || mp_take;
    assign fifo_in    = d_i[BYTE_W-1:0];

    cfg_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (fifo_in),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // Internal sink eats one byte per pacing period
    assign f_out_ready = st_ff == ST_LOAD && sink_ff == '0;
    assign pop         = f_out_valid && f_out_ready;
    assign load_end    = pop && bytes_ff == CFG_LAST;

    // Configuration sequence
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_POWER: if (tmr_ff == TMR_W'(POR_CYC - 1)) nxt_st = ST_CLEAR;
            ST_CLEAR: if (tmr_ff == TMR_W'(CLEAR_CYC - 1)) nxt_st = ST_WAIT;
            ST_WAIT:  if (init_i) nxt_st = ST_LOAD;
            ST_LOAD:  if (load_end) nxt_st = ST_DONE;
            ST_DONE:  nxt_st = ST_DONE;
            default:  nxt_st = ST_POWER;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_ff   <= ST_POWER;
            tmr_ff  <= '0;
            mode_ff <= MODE_ASYNC;
        end
        else
        begin
            st_ff   <= nxt_st;
            tmr_ff  <= (nxt_st != st_ff) ? '0 : tmr_ff + 1'b1;
            if (st_ff == ST_WAIT && init_i)
                mode_ff <= cfg_mode;
        end
    end

    // Fetch address, read clock, sink pacing and byte count
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            mem_addr_ff <= '0;
            rclk_ff     <= 1'b0;
            mp_done_ff  <= 1'b0;
            sink_ff     <= '0;
            bytes_ff    <= '0;
        end
        else
        begin
            if (mp_take)
                mem_addr_ff <= mem_addr_ff + 1'b1;
            if (rclk_step)
                rclk_ff <= !rclk_ff;
            if (mp_take && mem_addr_ff == CFG_LAST)
                mp_done_ff <= 1'b1;
            sink_ff  <= pop ? CONSUME_CYC - 3'h1 : (sink_ff != '0 ? sink_ff - 3'h1 : sink_ff);
            bytes_ff <= pop ? bytes_ff + 1'b1 : bytes_ff;
        end
    end

    // Ready only when nothing is queued or being consumed
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            ready_ff <= 1'b0;
        else
            ready_ff <= async_ld && !take && !f_out_valid && sink_ff == '0 && !load_end;
    end

    // Host bus: one beat per cycle, burst while continue holds
    assign h_start = hs_ff == HS_IDLE && st_ff == ST_DONE && mode_ff == MODE_HOST
                     && selected && !host_transfer_strobe;
    assign h_beat  = hs_ff == HS_BEAT;
    assign h_more  = !req_ff.burst_n && host_burst_continue && beat_ff != BEAT_LAST;
    assign widx    = req_ff.addr[WIDX_LSB +: 2] + beat_ff;
    assign sh      = {req_ff.addr[1:0], 3'h0};
    assign bmask   = lane_mask(req_ff.size) << sh;
    assign rword   = (hmem_ff[widx] >> sh) & lane_mask(req_ff.size);
    assign wword   = (hmem_ff[widx] & ~bmask) | ((d_i << sh) & bmask);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            hs_ff    <= HS_IDLE;
            req_ff   <= '0;
            beat_ff  <= '0;
            ack_n_ff <= 1'b1;
        end
        else
        begin
            if (h_start)
                req_ff <= '{rd: host_read_not_write, addr: host_addr,
                            size: host_xfer_size, burst_n: host_burst_n};
            hs_ff    <= h_start ? HS_BEAT : (h_beat && !h_more ? HS_IDLE : hs_ff);
            beat_ff  <= h_start ? '0 : (h_beat ? beat_ff + 1'b1 : beat_ff);
            ack_n_ff <= !h_beat;
        end
    end

    // Host write store
    genvar w;
    generate
        for (w = 0; w < HOST_WORDS; w++)
        begin : g_word
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                    hmem_ff[w] <= '0;
                else if (h_beat && !req_ff.rd && widx == 2'(w))
                    hmem_ff[w] <= wword;
            end
        end
    endgenerate

    // Data pin drive: host read lanes, else status on bits 7:3 of the low byte lane
    always_comb
    begin
        nxt_d_o  = '0;
        nxt_d_oe = '0;
        if (h_beat && req_ff.rd)
        begin
            nxt_d_o  = rword;
            nxt_d_oe = lane_mask(req_ff.size);
        end
        else if (rd_act)
        begin
            nxt_d_o[7:STAT_LSB] = {ready_ff, !f_in_ready, !f_out_valid, init_i, 1'b0};
            nxt_d_oe            = STAT_OE;
        end
    end

    // Pin-level status outputs
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            d_o_ff       <= '0;
            d_oe_ff      <= '0;
            busy_h_ff    <= 1'b1;
            busy_l_ff    <= 1'b0;
            init_o_ff    <= 1'b0;
            init_oe_ff   <= 1'b1;
            bscan_off_ff <= 1'b0;
            rw_user_ff   <= 1'b0;
            strb_o_ff    <= 1'b0;
            strb_oe_ff   <= 1'b0;
        end
        else
        begin
            d_o_ff       <= nxt_d_o;
            d_oe_ff      <= nxt_d_oe;
            busy_h_ff    <= nxt_st != ST_DONE;
            busy_l_ff    <= nxt_st == ST_DONE;
            init_o_ff    <= 1'b0;
            init_oe_ff   <= nxt_st == ST_POWER || nxt_st == ST_CLEAR;
            bscan_off_ff <= st_ff == ST_DONE && !bscan_sel;
            rw_user_ff   <= st_ff == ST_DONE && mode_ff != MODE_HOST;
            strb_o_ff    <= !h_start && !(h_beat && h_more);
            strb_oe_ff   <= strb_stat_en && st_ff == ST_DONE && mode_ff == MODE_HOST;
        end
    end

    assign host_xfer_ack_n = ack_n_ff;
    assign d_o             = d_o_ff;
    assign d_oe            = d_oe_ff;
    assign ready_o         = ready_ff;
    assign rclk_o          = rclk_ff;
    assign mem_addr_o      = mem_addr_ff;
    assign cfg_busy_high   = busy_h_ff;
    assign cfg_busy_low    = busy_l_ff;
    assign init_o          = init_o_ff;
    assign init_oe         = init_oe_ff;
    assign bscan_off       = bscan_off_ff;
    assign rw_user_io      = rw_user_ff;
    assign strb_o          = strb_o_ff;
    assign strb_oe         = strb_oe_ff;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_host_start;
        h_start;
    endsequence

    sequence s_beat_acked;
        h_beat ##1 !host_xfer_ack_n;
    endsequence

    a_write_wins: assert property (wr_act |=> d_oe[7] == 1'b0)
        else $error("read status driven during write");
    a_status_lanes: assert property (rd_act && !h_beat |=> d_oe == STAT_OE && d_o[7] == $past(ready_ff))
        else $error("status lanes wrong on read strobe");
    a_ready_held: assert property (take |=> !ready_o [*3])
        else $error("ready rose before byte consumed");
    a_busy_levels: assert property (st_ff == ST_LOAD |=>
        cfg_busy_high == (st_ff != ST_DONE) && cfg_busy_low == (st_ff == ST_DONE))
        else $error("busy outputs wrong during load");
    a_init_drive: assert property (st_ff == ST_CLEAR && nxt_st == ST_CLEAR |=> init_oe && !init_o)
        else $error("init not driven low during clear");
    a_wait_init: assert property (st_ff == ST_WAIT && !init_i |=> st_ff == ST_WAIT)
        else $error("left wait while init held low");
    a_ack_beat: assert property (s_host_start |=> s_beat_acked)
        else $error("no acknowledge after strobe");
    a_burst_abort: assert property (h_beat && !host_burst_continue |=> hs_ff == HS_IDLE ##1 host_xfer_ack_n)
        else $error("burst continued after abort");
    a_fetch_step: assert property (mp_take |=> !rclk_o && mem_addr_o == $past(mem_addr_o) + 22'h1)
        else $error("fetch address or clock wrong");

endmodule : config_and_host_port_pins

// ### design/strobe_sync.sv
/*
 Two-flop synchroniser with falling-edge pulse for active-low strobes.
 Assumes strobes are asynchronous to clk_sys.
*/
module strobe_sync
(
    input  wire logic       clk_sys,   // System clock
    input  wire logic       rstn,      // Async reset, active low
    input  wire logic [1:0] strobe_n,  // Raw strobes
    output logic      [1:0] level_n,   // Synchronised level
    output logic      [1:0] fall       // One-cycle falling pulse
);
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;
    logic [1:0] last_ff;

    // Each strobe bit synchronised alone
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_bit
            always_ff @(posedge clk_sys or negedge rstn)
            begin
                if (!rstn)
                begin
                    meta_ff[g] <= 1'b1;
                    sync_ff[g] <= 1'b1;
                    last_ff[g] <= 1'b1;
                end
                else
                begin
                    meta_ff[g] <= strobe_n[g];
                    sync_ff[g] <= meta_ff[g];
                    last_ff[g] <= sync_ff[g];
                end
            end
            assign fall[g] = last_ff[g] & ~sync_ff[g];
        end
    endgenerate

    assign level_n = sync_ff;

endmodule : strobe_sync

// ### verif/cfg_mem_model.sv
/*
 Configuration memory model for master parallel loads.
 Assumes the loader samples data only while its read clock is high.
*/
module cfg_mem_model
(
    input  wire logic        clk_sys, // System clock
    input  wire logic        rclk,    // Read clock from loader
    input  wire logic [21:0] addr,    // Byte address
    output logic      [7:0]  q        // Byte at addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q_ff;
    // Data follows the address a cycle late; inverted junk while rclk low
    always @(posedge clk_sys)
        q_ff <= addr[7:0] ^ 8'h5c;
    assign q = rclk ? q_ff : ~q_ff;
endmodule : cfg_mem_model

// ### verif/config_and_host_port_pins_tb_top.sv
/*
 Self-checking bench: async, master and host-bus modes in turn.
 Assumes the design instance runs with a 4-byte configuration image.
*/
module config_and_host_port_pins_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_pins_pkg::*;
    logic clk_sys = 0, rstn = 0, bscan_sel = 0, sel_n = 0, sel_h = 1, strb = 1, rw = 1;
    logic bn = 1, bc = 0, hold = 0, ack_n, ready_o, rclk_o, bh, bl, init_i, init_o, init_oe;
    logic bscan_off, rw_user_io, strb_o, strb_oe, sen = 0, prev;
    cfg_mode_t mode = MODE_ASYNC;
    logic [17:0] addr = 18'h0;
    logic [1:0] sz = 2'h0;
    logic [31:0] d_drv = 32'h0, d_i, d_o, d_oe, wd [4], rq [4], ex [4];
    logic [21:0] mem_addr_o;
    logic [7:0] mq;
    int seed = 97088, checks = 0, bad_count = 0, n, k;
    // Open-drain init line with pull-up; bench may hold it low too
    assign init_i = !(init_oe || hold);
    assign d_i = (mode == MODE_MASTER) ? {24'h0, mq} : d_drv;
    always #25 clk_sys = ~clk_sys;
    config_and_host_port_pins #(.CFG_BYTES(22'h4)) i_config_and_host_port_pins (
        .clk_sys(clk_sys), .rstn(rstn), .cfg_mode(mode), .bscan_sel(bscan_sel),
        .strb_stat_en(sen), .select_low_n(sel_n), .select_high(sel_h),
        .host_transfer_strobe(strb), .host_read_not_write(rw), .host_addr(addr),
        .host_burst_n(bn), .host_burst_continue(bc), .host_xfer_size(sz),
        .host_xfer_ack_n(ack_n), .d_i(d_i), .d_o(d_o), .d_oe(d_oe), .ready_o(ready_o),
        .rclk_o(rclk_o), .mem_addr_o(mem_addr_o), .cfg_busy_high(bh), .cfg_busy_low(bl),
        .init_i(init_i), .init_o(init_o), .init_oe(init_oe), .bscan_off(bscan_off),
        .rw_user_io(rw_user_io), .strb_o(strb_o), .strb_oe(strb_oe));
    cfg_mem_model i_cfg_mem_model (.clk_sys(clk_sys), .rclk(rclk_o), .addr(mem_addr_o), .q(mq));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
            bad_count++;
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // Lanes touched by a sized host write at a byte offset
    function automatic logic [31:0] merge(input logic [31:0] o, w, input logic [1:0] s, off);
        logic [31:0] m;
        m = (s == TSZ_BYTE) ? 32'hff : (s == TSZ_HALF) ? 32'hffff : 32'hffff_ffff;
        m = m << (off * 8);
        return (o & ~m) | ((w << (off * 8)) & m);
    endfunction : merge
    task automatic rst(input cfg_mode_t m);
        rstn = 0;
        mode = m;
        repeat (8) @(negedge clk_sys);
        rstn = 1;
        repeat (135) @(negedge clk_sys);
        chk(init_oe, 1);
        chk(bh, 1);
        chk(bl, 0);
        chk(init_o, 0);
        repeat (10) @(negedge clk_sys);
        chk(init_oe, 0);
    endtask : rst
    task automatic wrdy();
        for (int i = 0; i < 40 && ready_o !== 1'b1; i++)
            @(negedge clk_sys);
        chk(ready_o, 1);
    endtask : wrdy
    // Waits for room first: ready stays low once the last byte is in
    task automatic wb(input logic [7:0] b);
        wrdy();
        d_drv = {24'h0, b};
        rw = 0;
        repeat (5) @(negedge clk_sys);
        chk(ready_o, 0);
        rw = 1;
        repeat (3) @(negedge clk_sys);
    endtask : wb
    // One host transfer; counts acks and keeps read data per beat
    task automatic hx(input logic r, input logic [17:0] a, input logic [1:0] s, input logic b, c);
        @(negedge clk_sys);
        rw = r;
        addr = a;
        sz = s;
        bn = b;
        bc = c;
        strb = 0;
        d_drv = wd[0];
        n = 0;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk_sys);
            strb = 1;
            if (i < 4)
                d_drv = wd[i];
            if (ack_n === 1'b0 && n < 4)
            begin
                rq[n] = d_o;
                n++;
            end
        end
        bc = 0;
        bn = 1;
    endtask : hx

    // Main sequence
    initial
    begin
        rst(MODE_ASYNC);
        sel_h = 0;
        rw = 0;
        repeat (6) @(negedge clk_sys);
        rw = 1;
        repeat (4) @(negedge clk_sys);
        chk(ready_o, 1);
        sel_h = 1;
        strb = 0;
        d_drv = 32'(8'($random(seed)));
        repeat (4) @(negedge clk_sys);
        chk(d_oe, 32'hf8);
        chk(32'(d_o[7]), 1);
        rw = 0;
        repeat (4) @(negedge clk_sys);
        chk(d_oe, 0);
        rw = 1;
        strb = 1;
        repeat (3) @(negedge clk_sys);
        wrdy();
        for (k = 0; k < 3; k++)
            wb(8'($random(seed)));
        repeat (10) @(negedge clk_sys);
        chk({bh, bl, bscan_off, rw_user_io, ready_o}, 5'he);
        // Master load held off by init, then walks addresses
        hold = 1;
        bscan_sel = 1;
        rst(MODE_MASTER);
        repeat (30) @(negedge clk_sys);
        chk({rclk_o, mem_addr_o}, 0);
        hold = 0;
        k = 0;
        prev = 1'b0;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge clk_sys);
            if (rclk_o === 1'b1 && prev === 1'b0 && k < 8)
            begin
                chk(32'(mem_addr_o), k);
                k++;
            end
            prev = rclk_o;
        end
        chk(k, 4);
        chk({bh, bl, bscan_off, rw_user_io}, 4'h5);
        // Host mode: load, then sized and burst transfers
        bscan_sel = 0;
        rst(MODE_HOST);
        for (k = 0; k < 4; k++)
            wb(8'($random(seed)));
        repeat (10) @(negedge clk_sys);
        chk({rw_user_io, strb_oe, strb_o}, 3'h1);
        sen = 1;
        repeat (2) @(negedge clk_sys);
        chk({rw_user_io, strb_oe, strb_o}, 3'h3);
        for (k = 0; k < 4; k++)
            wd[k] = $random(seed);
        ex = wd;
        hx(0, 18'h0, TSZ_WORD, 0, 1);
        chk(n, 4);
        for (k = 0; k < 2; k++)
        begin
            wd[0] = $random(seed);
            hx(0, 18'h4 + 18'(k + 1), k ? TSZ_HALF : TSZ_BYTE, 1, 0);
            chk(n, 1);
            ex[1] = merge(ex[1], wd[0], k ? TSZ_HALF : TSZ_BYTE, 2'(k + 1));
        end
        hx(1, 18'h0, TSZ_WORD, 0, 1);
        chk(n, 4);
        for (k = 0; k < 4; k++)
            chk(rq[k], ex[k]);
        hx(1, 18'h8, TSZ_WORD, 0, 0);
        chk(n, 1);
        chk(rq[0], ex[2]);
        test_done();
    end
    // Watchdog: whole run is about a thousand cycles, allow 20000
    initial
    begin
        #1ms;
        bad_count++;
        test_done();
    end
endmodule : config_and_host_port_pins_tb_top
